// ---- core/input_function_mapper_defines.vh ----
// Selection codes, reset defaults and widths of the input function mapper
`ifndef INPUT_FUNCTION_MAPPER_DEFINES_VH
`define INPUT_FUNCTION_MAPPER_DEFINES_VH

// ****************************************************************
// Widths
// ****************************************************************
`define IFM_TERMINALS        8
`define IFM_CODE_W           6
`define IFM_IDX_W            3
`define IFM_SYNC_RST         1'b0

// ****************************************************************
// Selection codes
// ****************************************************************
`define IFM_CODE_NONE        6'h00
`define IFM_CODE_CONT_POS    6'h01
`define IFM_CODE_CONT_NEG    6'h02
`define IFM_CODE_ORIGIN      6'h03
`define IFM_CODE_POSITION    6'h04
`define IFM_CODE_SEQ         6'h05
`define IFM_CODE_INCH_POS    6'h06
`define IFM_CODE_INCH_NEG    6'h07
`define IFM_CODE_DIRECT_0    6'h08
`define IFM_CODE_RELEASE     6'h10
`define IFM_CODE_EXCITE      6'h11
`define IFM_CODE_HALT        6'h12
`define IFM_CODE_ALM_CLR     6'h18
`define IFM_CODE_PRESET      6'h19
`define IFM_CODE_ABS_CLR     6'h1A
`define IFM_CODE_LOCKOUT     6'h1B
`define IFM_CODE_GENERAL_0   6'h20
`define IFM_CODE_DATA_0      6'h30

// ****************************************************************
// Reset values
// ****************************************************************
`define IFM_RST_SEL_0        6'h03
`define IFM_RST_SEL_1        6'h04
`define IFM_RST_SEL_2        6'h30
`define IFM_RST_SEL_3        6'h31
`define IFM_RST_SEL_4        6'h32
`define IFM_RST_SEL_5        6'h10
`define IFM_RST_SEL_6        6'h12
`define IFM_RST_SEL_7        6'h18
`define IFM_RST_POLARITY     8'h00

`endif

// ---- core/terminal_sampler.v ----
// Two-stage sampler with per-terminal polarity for the input terminals
`timescale 1ns/1ns
`include "input_function_mapper_defines.vh"

module terminal_sampler (
   input  wire       i_clk,
   input  wire       i_sys_rst,
   input  wire [7:0] i_raw,
   input  wire [7:0] i_polarity,
   output wire [7:0] o_level
);

   reg [7:0] stage1_reg;
   reg [7:0] stage2_reg;

   // ****************************************************************
   // Sampling
   // ****************************************************************
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         stage1_reg <= {8{`IFM_SYNC_RST}};
         stage2_reg <= {8{`IFM_SYNC_RST}};
      end else begin
         stage1_reg <= i_raw;          // see R19
         stage2_reg <= stage1_reg;
      end
   end

   // Normally closed terminals are inverted
   assign o_level = stage2_reg ^ i_polarity;   // see R18

endmodule // terminal_sampler

// ---- core/transition_pulse.v ----
// One-cycle pulse on a chosen transition of a function level
`timescale 1ns/1ns

module transition_pulse #(
   parameter RISING = 1
) (
   input  wire i_clk,
   input  wire i_sys_rst,
   input  wire i_level,
   output wire o_pulse
);

   reg prev_reg;
   reg pulse_reg;

   // ****************************************************************
   // Edge detection
   // ****************************************************************
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         prev_reg  <= 1'b0;
         pulse_reg <= 1'b0;
      end else begin
         prev_reg <= i_level;
         if (RISING != 0) begin
            pulse_reg <= i_level & ~prev_reg;
         end else begin
            pulse_reg <= ~i_level & prev_reg;
         end
      end
   end

   assign o_pulse = pulse_reg;

endmodule // transition_pulse

// ---- core/input_function_mapper.v ----
// Maps eight input terminals onto internal command functions
//
// Operation
// R1 - Each terminal has a selection code; code 0 drives no function.
// R2 - Codes 1 and 2 drive continuous motion positive and negative.
// R3 - Code 3 origin return, 4 positioning trigger, 5 sequential trigger.
// R4 - Codes 6 and 7 drive inch positive and inch negative.
// R5 - Codes 8 to 13 drive the six direct position selects.
// R6 - Code 16 drives release-hold, removing excitation and freeing brake.
// R7 - Code 17 drives excitation control, code 18 motion halt.
// R8 - Codes 24 to 27: alarm clear, preset, abs clear, lockout release.
// R9 - Codes 32 to 47 drive sixteen general signals for serial control.
// R10 - Codes 48 to 53 drive the six data number bits.
// R11 - Reset defaults: 3, 4, 48, 49, 50, 16, 18, 24.
// R12 - A function on several terminals is active if any is active.
// R13 - Alarm clear and abs error clear act on active-to-inactive.
// R14 - Position preset acts on inactive-to-active.
// R15 - Unassigned excitation control or lockout release is held active.
// R16 - Assigned both locally and remotely, both sources must be active.
// R17 - Remote inputs are the same functions written over the serial link.
// R18 - Per-terminal polarity, default 0 normally open, 1 inverts level.
// R19 - Unlisted codes drive nothing; terminals sampled on the clock.
`timescale 1ns/1ns
`include "input_function_mapper_defines.vh"

module input_function_mapper (
   input  wire        i_clk,
   input  wire        i_sys_rst,
   input  wire [7:0]  i_input_connector,
   input  wire        i_sel_wr_en,
   input  wire [2:0]  i_sel_wr_index,
   input  wire [5:0]  i_sel_wr_code,
   input  wire [2:0]  i_sel_rd_index,
   input  wire        i_pol_wr_en,
   input  wire [7:0]  i_pol_wr_data,
   input  wire        i_remote_excite_assigned,
   input  wire        i_remote_excite,
   input  wire        i_remote_lockout_assigned,
   input  wire        i_remote_lockout,
   output wire [5:0]  o_sel_rd_code,
   output wire [7:0]  o_polarity,
   output wire [7:0]  o_terminal_level,
   output wire        o_continuous_positive,
   output wire        o_continuous_negative,
   output wire        o_origin_return,
   output wire        o_position_trigger,
   output wire        o_sequential_trigger,
   output wire        o_inch_positive,
   output wire        o_inch_negative,
   output wire [5:0]  o_direct_position_select,
   output wire        o_release_hold,
   output wire        o_excitation_on,
   output wire        o_motion_halt,
   output wire        o_alarm_clear,
   output wire        o_position_preset,
   output wire        o_abs_error_clear,
   output wire        o_panel_lockout_release,
   output wire [15:0] o_general_signal,
   output wire [5:0]  o_data_number
);

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Any terminal selecting code and active
   function func_active;
      input [47:0] sels;
      input [7:0]  lv;
      input [5:0]  code;
      integer      k;
      begin
         func_active = 1'b0;
         for (k = 0; k < 8; k = k + 1) begin
            if (sels[k*6 +: 6] == code && lv[k]) begin
               func_active = 1'b1;                    // see R12
            end
         end
      end
   endfunction

   // Any terminal selecting code at all
   function func_assigned;
      input [47:0] sels;
      input [5:0]  code;
      integer      k;
      begin
         func_assigned = 1'b0;
         for (k = 0; k < 8; k = k + 1) begin
            if (sels[k*6 +: 6] == code) begin
               func_assigned = 1'b1;
            end
         end
      end
   endfunction

   // Local and remote sources of a held-on function
   function held_on;
      input local_assigned;
      input local_level;
      input remote_assigned;
      input remote_level;
      begin
         if (!local_assigned && !remote_assigned) begin
            held_on = 1'b1;                            // see R15
         end else if (local_assigned && remote_assigned) begin
            held_on = local_level & remote_level;      // see R16
         end else if (local_assigned) begin
            held_on = local_level;
         end else begin
            held_on = remote_level;                    // see R17
         end
      end
   endfunction

   // ****************************************************************
   // Selection and polarity settings
   // ****************************************************************
   reg  [5:0]  sel_reg [0:7];
   reg  [7:0]  polarity_reg;
   wire [47:0] sels;
   integer     n;

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         sel_reg[0]   <= `IFM_RST_SEL_0;               // see R11
         sel_reg[1]   <= `IFM_RST_SEL_1;
         sel_reg[2]   <= `IFM_RST_SEL_2;
         sel_reg[3]   <= `IFM_RST_SEL_3;
         sel_reg[4]   <= `IFM_RST_SEL_4;
         sel_reg[5]   <= `IFM_RST_SEL_5;
         sel_reg[6]   <= `IFM_RST_SEL_6;
         sel_reg[7]   <= `IFM_RST_SEL_7;
         polarity_reg <= `IFM_RST_POLARITY;            // see R18
      end else begin
         for (n = 0; n < 8; n = n + 1) begin
            if (i_sel_wr_en && i_sel_wr_index == n[2:0]) begin
               sel_reg[n] <= i_sel_wr_code;            // see R1
            end
         end
         if (i_pol_wr_en) begin
            polarity_reg <= i_pol_wr_data;
         end
      end
   end

   assign sels = {sel_reg[7], sel_reg[6], sel_reg[5], sel_reg[4],
                  sel_reg[3], sel_reg[2], sel_reg[1], sel_reg[0]};
   assign o_sel_rd_code = sel_reg[i_sel_rd_index];
   assign o_polarity    = polarity_reg;

   // ****************************************************************
   // Terminal sampling
   // ****************************************************************
   wire [7:0] level;

   terminal_sampler u_sampler (
      .i_clk      (i_clk),
      .i_sys_rst  (i_sys_rst),
      .i_raw      (i_input_connector),
      .i_polarity (polarity_reg),
      .o_level    (level)
   );

   assign o_terminal_level = level;

   // ****************************************************************
   // Function decode
   // ****************************************************************
   reg        cont_pos_next;
   reg        cont_neg_next;
   reg        origin_next;
   reg        position_next;
   reg        seq_next;
   reg        inch_pos_next;
   reg        inch_neg_next;
   reg [5:0]  direct_next;
   reg        release_next;
   reg        excite_next;
   reg        halt_next;
   reg        lockout_next;
   reg [15:0] general_next;
   reg [5:0]  data_next;
   reg        alm_level;
   reg        preset_level;
   reg        abs_level;
   integer    j;

   // Codes outside the listed set match nothing
   always @* begin
      cont_pos_next = func_active(sels, level, `IFM_CODE_CONT_POS); // see R2
      cont_neg_next = func_active(sels, level, `IFM_CODE_CONT_NEG);
      origin_next   = func_active(sels, level, `IFM_CODE_ORIGIN);   // see R3
      position_next = func_active(sels, level, `IFM_CODE_POSITION);
      seq_next      = func_active(sels, level, `IFM_CODE_SEQ);
      inch_pos_next = func_active(sels, level, `IFM_CODE_INCH_POS); // see R4
      inch_neg_next = func_active(sels, level, `IFM_CODE_INCH_NEG);
      for (j = 0; j < 6; j = j + 1) begin
         direct_next[j] = func_active(sels, level,
            `IFM_CODE_DIRECT_0 + j[5:0]);                          // see R5
         data_next[j]   = func_active(sels, level,
            `IFM_CODE_DATA_0 + j[5:0]);                            // see R10
      end
      for (j = 0; j < 16; j = j + 1) begin
         general_next[j] = func_active(sels, level,
            `IFM_CODE_GENERAL_0 + j[5:0]);                         // see R9
      end
      release_next = func_active(sels, level, `IFM_CODE_RELEASE);  // see R6
      halt_next    = func_active(sels, level, `IFM_CODE_HALT);     // see R7
      excite_next  = held_on(
         func_assigned(sels, `IFM_CODE_EXCITE),
         func_active(sels, level, `IFM_CODE_EXCITE),
         i_remote_excite_assigned, i_remote_excite);               // see R7
      lockout_next = held_on(
         func_assigned(sels, `IFM_CODE_LOCKOUT),
         func_active(sels, level, `IFM_CODE_LOCKOUT),
         i_remote_lockout_assigned, i_remote_lockout);             // see R8
      alm_level    = func_active(sels, level, `IFM_CODE_ALM_CLR);  // see R8
      preset_level = func_active(sels, level, `IFM_CODE_PRESET);
      abs_level    = func_active(sels, level, `IFM_CODE_ABS_CLR);
   end

   // ****************************************************************
   // Level outputs
   // ****************************************************************
   reg        cont_pos_reg;
   reg        cont_neg_reg;
   reg        origin_reg;
   reg        position_reg;
   reg        seq_reg;
   reg        inch_pos_reg;
   reg        inch_neg_reg;
   reg [5:0]  direct_reg;
   reg        release_reg;
   reg        excite_reg;
   reg        halt_reg;
   reg        lockout_reg;
   reg [15:0] general_reg;
   reg [5:0]  data_reg;

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         cont_pos_reg <= 1'b0;
         cont_neg_reg <= 1'b0;
         origin_reg   <= 1'b0;
         position_reg <= 1'b0;
         seq_reg      <= 1'b0;
         inch_pos_reg <= 1'b0;
         inch_neg_reg <= 1'b0;
         direct_reg   <= 6'h00;
         release_reg  <= 1'b0;
         excite_reg   <= 1'b0;
         halt_reg     <= 1'b0;
         lockout_reg  <= 1'b0;
         general_reg  <= 16'h0000;
         data_reg     <= 6'h00;
      end else begin
         cont_pos_reg <= cont_pos_next;
         cont_neg_reg <= cont_neg_next;
         origin_reg   <= origin_next;
         position_reg <= position_next;
         seq_reg      <= seq_next;
         inch_pos_reg <= inch_pos_next;
         inch_neg_reg <= inch_neg_next;
         direct_reg   <= direct_next;
         release_reg  <= release_next;
         excite_reg   <= excite_next;
         halt_reg     <= halt_next;
         lockout_reg  <= lockout_next;
         general_reg  <= general_next;
         data_reg     <= data_next;
      end
   end

   // ****************************************************************
   // Transition-triggered functions
   // ****************************************************************
   transition_pulse #(
      .RISING (0)
   ) u_alarm_clear (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_level   (alm_level),
      .o_pulse   (o_alarm_clear)
   );                                                           // see R13

   transition_pulse #(
      .RISING (0)
   ) u_abs_error_clear (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_level   (abs_level),
      .o_pulse   (o_abs_error_clear)
   );                                                           // see R13

   transition_pulse #(
      .RISING (1)
   ) u_position_preset (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_level   (preset_level),
      .o_pulse   (o_position_preset)
   );                                                           // see R14

   // ****************************************************************
   // Output assignments
   // ****************************************************************
   assign o_continuous_positive    = cont_pos_reg;
   assign o_continuous_negative    = cont_neg_reg;
   assign o_origin_return          = origin_reg;
   assign o_position_trigger       = position_reg;
   assign o_sequential_trigger     = seq_reg;
   assign o_inch_positive          = inch_pos_reg;
   assign o_inch_negative          = inch_neg_reg;
   assign o_direct_position_select = direct_reg;
   assign o_release_hold           = release_reg;
   assign o_excitation_on          = excite_reg;
   assign o_motion_halt            = halt_reg;
   assign o_panel_lockout_release  = lockout_reg;
   assign o_general_signal         = general_reg;
   assign o_data_number            = data_reg;

endmodule // input_function_mapper

// ---- sim/ifm_monitor.sv ----
// Port-level checker for the input function mapper
`timescale 1ns/1ns
`include "input_function_mapper_defines.vh"

module ifm_monitor (
   input wire       i_clk,
   input wire       i_sys_rst,
   input wire [7:0] i_input_connector,
   input wire       i_sel_wr_en,
   input wire [2:0] i_sel_wr_index,
   input wire [5:0] i_sel_wr_code,
   input wire [2:0] i_sel_rd_index,
   input wire       i_pol_wr_en,
   input wire [7:0] i_pol_wr_data,
   input wire       i_remote_excite_assigned,
   input wire       i_remote_excite,
   input wire       i_remote_lockout_assigned,
   input wire       i_remote_lockout,
   input wire [5:0] o_sel_rd_code,
   input wire [7:0] o_polarity,
   input wire [7:0] o_terminal_level,
   input wire       o_excitation_on,
   input wire       o_panel_lockout_release,
   input wire       o_alarm_clear,
   input wire       o_position_preset
);
   localparam [47:0] DEF_SEL = {`IFM_RST_SEL_7, `IFM_RST_SEL_6,
      `IFM_RST_SEL_5, `IFM_RST_SEL_4, `IFM_RST_SEL_3, `IFM_RST_SEL_2,
      `IFM_RST_SEL_1, `IFM_RST_SEL_0};
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   sequence s_sel_taken;
      i_sel_wr_en ##1 i_sel_rd_index == $past(i_sel_wr_index);
   endsequence
   sequence s_alm_pulse;
      o_alarm_clear ##1 !o_alarm_clear;
   endsequence
   property p_sel_wr;
      s_sel_taken |-> o_sel_rd_code == $past(i_sel_wr_code);
   endproperty
   property p_sel_def;
      $past(i_sys_rst) |-> o_sel_rd_code == DEF_SEL[i_sel_rd_index*6 +: 6];
   endproperty
   property p_rst_out;
      $past(i_sys_rst) |-> o_polarity == 8'h00 && !o_alarm_clear
         && !o_position_preset && !o_excitation_on;
   endproperty
   property p_pol_wr;
      !$past(i_sys_rst) && $past(i_pol_wr_en)
         |-> o_polarity == $past(i_pol_wr_data);
   endproperty
   property p_sync;
      !$past(i_sys_rst) && !$past(i_sys_rst, 2)
         |-> o_terminal_level == ($past(i_input_connector, 2) ^ o_polarity);
   endproperty
   property p_excite;
      !$past(i_sys_rst) && $past(i_remote_excite_assigned && !i_remote_excite)
         |-> !o_excitation_on;
   endproperty
   property p_lockout;
      !$past(i_sys_rst)
         && $past(i_remote_lockout_assigned && !i_remote_lockout)
         |-> !o_panel_lockout_release;
   endproperty
   property p_alm;
      o_alarm_clear |-> s_alm_pulse;
   endproperty
   property p_preset;
      $rose(o_position_preset) |=> $fell(o_position_preset);
   endproperty
   a_sel_wr: assert property (p_sel_wr)
      else $error("selection code write lost");
   a_sel_def: assert property (p_sel_def)
      else $error("wrong default selection code");
   a_rst_out: assert property (p_rst_out)
      else $error("outputs not cleared by reset");
   a_pol_wr: assert property (p_pol_wr)
      else $error("polarity write lost");
   a_sync: assert property (p_sync)
      else $error("terminal level latency or polarity wrong");
   a_excite: assert property (p_excite)
      else $error("excitation on while remote source inactive");
   a_lockout: assert property (p_lockout)
      else $error("lockout release on while remote source inactive");
   a_alm: assert property (p_alm)
      else $error("alarm clear pulse longer than one cycle");
   a_preset: assert property (p_preset)
      else $error("preset pulse longer than one cycle");
endmodule // ifm_monitor

bind input_function_mapper ifm_monitor u_ifm_monitor (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_input_connector(i_input_connector), .i_sel_wr_en(i_sel_wr_en),
   .i_sel_wr_index(i_sel_wr_index), .i_sel_wr_code(i_sel_wr_code),
   .i_sel_rd_index(i_sel_rd_index), .i_pol_wr_en(i_pol_wr_en),
   .i_pol_wr_data(i_pol_wr_data),
   .i_remote_excite_assigned(i_remote_excite_assigned),
   .i_remote_excite(i_remote_excite),
   .i_remote_lockout_assigned(i_remote_lockout_assigned),
   .i_remote_lockout(i_remote_lockout), .o_sel_rd_code(o_sel_rd_code),
   .o_polarity(o_polarity), .o_terminal_level(o_terminal_level),
   .o_excitation_on(o_excitation_on),
   .o_panel_lockout_release(o_panel_lockout_release),
   .o_alarm_clear(o_alarm_clear), .o_position_preset(o_position_preset));

// ---- sim/terminal_switches.sv ----
// Behavioural switch bank on the input terminals
`timescale 1ns/1ns

module terminal_switches (
   input  wire        i_clk,
   input  wire  [7:0] i_want,
   output logic [7:0] o_pins
);
   initial o_pins = 8'h00;
   // Contacts follow the command just after each rising edge
   always @(posedge i_clk) begin
      o_pins <= #1 i_want;
   end
endmodule // terminal_switches

// ---- sim/tb_top.sv ----
// Self-checking testbench for the input function mapper
`timescale 1ns/1ns
`include "input_function_mapper_defines.vh"

module tb_top;
   logic        i_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic [7:0]  want = 8'h00;
   logic        sel_en = 1'b0;
   logic [2:0]  sel_idx = 3'h0;
   logic [5:0]  sel_code = 6'h00;
   logic [2:0]  rd_idx = 3'h0;
   logic        pol_en = 1'b0;
   logic [7:0]  pol_data = 8'h00;
   logic [3:0]  rem = 4'h0;
   logic        e;
   wire  [7:0]  pins, pol, lvl;
   wire  [5:0]  rd_code, dir, dat;
   wire  [15:0] gen;
   wire         cp, cn, org, pos, seq, ip, inn, rel, exc, halt, alm, pre;
   wire         abc, lock;
   wire  [36:0] obs = {gen, dat, dir, halt, rel, inn, ip, seq, pos, org,
                       cn, cp};
   int          miscompares = 0, checks_done = 0, cycles = 0;
   int          n_alm = 0, n_pre = 0, n_abs = 0, a0, p0, b0;
   localparam logic [47:0] def_sel = {`IFM_RST_SEL_7, `IFM_RST_SEL_6,
      `IFM_RST_SEL_5, `IFM_RST_SEL_4, `IFM_RST_SEL_3, `IFM_RST_SEL_2,
      `IFM_RST_SEL_1, `IFM_RST_SEL_0};

   terminal_switches u_terminal_switches (.i_clk(i_clk), .i_want(want),
      .o_pins(pins));
   input_function_mapper u_input_function_mapper (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_input_connector(pins),
      .i_sel_wr_en(sel_en), .i_sel_wr_index(sel_idx),
      .i_sel_wr_code(sel_code), .i_sel_rd_index(rd_idx),
      .i_pol_wr_en(pol_en), .i_pol_wr_data(pol_data),
      .i_remote_excite_assigned(rem[1]), .i_remote_excite(rem[0]),
      .i_remote_lockout_assigned(rem[3]), .i_remote_lockout(rem[2]),
      .o_sel_rd_code(rd_code), .o_polarity(pol), .o_terminal_level(lvl),
      .o_continuous_positive(cp), .o_continuous_negative(cn),
      .o_origin_return(org), .o_position_trigger(pos),
      .o_sequential_trigger(seq), .o_inch_positive(ip),
      .o_inch_negative(inn), .o_direct_position_select(dir),
      .o_release_hold(rel), .o_excitation_on(exc), .o_motion_halt(halt),
      .o_alarm_clear(alm), .o_position_preset(pre),
      .o_abs_error_clear(abc), .o_panel_lockout_release(lock),
      .o_general_signal(gen), .o_data_number(dat));

   always #25 i_clk = ~i_clk;

   // Pulse counters and run limit
   always @(negedge i_clk) begin
      n_alm += (alm !== 1'b0);
      n_pre += (pre !== 1'b0);
      n_abs += (abc !== 1'b0);
   end
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 6000) begin
         miscompares++;
         close_out();
      end
   end

   task tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task do_reset();
      i_sys_rst = 1'b1;
      tick(10);
      i_sys_rst = 1'b0;
   endtask
   task set_sel(input logic [2:0] idx, input logic [5:0] code);
      sel_idx = idx;
      sel_code = code;
      sel_en = 1'b1;
      tick(1);
      sel_en = 1'b0;
      tick(1);
   endtask
   task set_pol(input logic [7:0] d);
      pol_data = d;
      pol_en = 1'b1;
      tick(1);
      pol_en = 1'b0;
      tick(1);
   endtask
   task drive(input logic [7:0] p);
      want = p;
      tick(6);
   endtask
   task chk_val(input logic [36:0] got, input logic [36:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task chk_cnt(input int got, input int exp);
      checks_done++;
      if (got != exp) begin
         miscompares++;
         $display("wrong value at %0t: count %0d expected %0d", $time, got,
                  exp);
      end
   endtask
   task close_out();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   function automatic logic [36:0] exp_vec(input int c);
      exp_vec = '0;
      if (c >= 1 && c <= 7) exp_vec[c-1] = 1'b1;
      if (c >= 8 && c <= 13) exp_vec[c+1] = 1'b1;
      if (c == 16) exp_vec[7] = 1'b1;
      if (c == 18) exp_vec[8] = 1'b1;
      if (c >= 32 && c <= 47) exp_vec[c-11] = 1'b1;
      if (c >= 48 && c <= 53) exp_vec[c-33] = 1'b1;
   endfunction

   initial begin
      do_reset();
      for (int i = 0; i < 8; i++) begin
         rd_idx = i[2:0];
         tick(1);
         chk_val(37'(rd_code), 37'(def_sel[i*6 +: 6]));
      end
      chk_val(37'(pol), 37'h0);
      chk_val(37'({exc, lock}), 37'h3);
      rd_idx = 3'h0;
      for (int c = 0; c < 64; c++) begin
         a0 = n_alm;
         p0 = n_pre;
         b0 = n_abs;
         set_sel(3'h0, c[5:0]);
         chk_val(37'(rd_code), 37'(c));
         drive(8'h01);
         chk_val(obs, exp_vec(c));
         chk_val(37'({exc, lock}), 37'h3);
         drive(8'h00);
         chk_val(obs, 37'h0);
         chk_val(37'({exc, lock}), 37'({c != 17, c != 27}));
         chk_cnt(n_alm - a0, c == 24);
         chk_cnt(n_pre - p0, c == 25);
         chk_cnt(n_abs - b0, c == 26);
      end
      set_sel(3'h1, `IFM_CODE_HALT);
      set_sel(3'h2, `IFM_CODE_HALT);
      for (int k = 0; k < 3; k++) begin
         drive(8'h02 << (k == 1) << (k == 2) * 5);
         chk_val(obs, exp_vec(18));
      end
      set_sel(3'h0, `IFM_CODE_ALM_CLR);
      a0 = n_alm;
      drive(8'h81);
      drive(8'h01);
      drive(8'h00);
      chk_cnt(n_alm - a0, 1);
      do_reset();
      set_pol(8'h01);
      drive(8'h00);
      chk_val(37'(lvl), 37'h01);
      chk_val(obs, exp_vec(3));
      drive(8'h01);
      chk_val(obs, 37'h0);
      for (int i = 0; i < 16; i++) begin
         set_sel(3'h3, i[3] ? `IFM_CODE_EXCITE : `IFM_CODE_NONE);
         set_sel(3'h4, i[3] ? `IFM_CODE_LOCKOUT : `IFM_CODE_NONE);
         rem = {i[2], i[1], i[2], i[1]};
         drive({3'h0, i[0], i[0], 3'h1});
         e = (i[3] ? i[0] : 1'b1) & (i[2] ? i[1] : 1'b1);
         chk_val(37'({exc, lock}), 37'({e, e}));
      end
      close_out();
   end
endmodule // tb_top
